/* File: hwm_alarm.sv */
// Purpose: limit checks, alarm status, interrupt and overheat outputs
// Assumes: host index bus with read and write strobes, one cycle each
// Notes: conversions come from outside as one done pulse per round
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// RULE1 - Sensor B reads 8-bit whole degrees, sensor A 9-bit half degrees
// RULE2 - Sensor A upper eight bits at 50h, its LSB in 51h bit 7
// RULE3 - Sensor B hysteresis of 127 selects comparator interrupt mode
// RULE4 - Sensor B comparator mode re-raises each conversion above limit after a clear
// RULE5 - Sensor A comparator mode re-raises after clear until below hysteresis
// RULE6 - Sensor B hysteresis below over-limit selects two-times mode
// RULE7 - Two-times: raise on over, raise again below hysteresis if cleared
// RULE8 - Sensor A one-time mode raises only on exceeding over-limit
// RULE9 - Overheat latch bit 0: output active above limit until below hysteresis
// RULE10 - Latch bit 1: output latches until temperature read, then on dropping
// RULE11 - Voltages two-times: leaving window raises if previous cleared
// RULE12 - Fans two-times: crossing count limit raises if previous cleared
// RULE13 - Reading the status registers clears pending status
// RULE14 - Config bit 7 restores defaults and self-clears
// RULE15 - Config bit 6 drives the buzzer output low
// RULE16 - Config bit 3 disables interrupt and halts monitoring, status kept
// RULE17 - Interrupt output driven only while config bit 1 is set
// RULE18 - Config bit 0 starts monitoring; zero means standby
// RULE19 - Writing zero to config does not release interrupt outputs
// RULE20 - Status one: fans, temperatures, rails, bit 1 reserved
// RULE21 - Status two: fan C and rails, upper nibble zero
// RULE22 - Mask one bits block matching status bits from interrupt
// RULE23 - Sensor A interrupt mode is programmable, comparator after reset
// RULE24 - Interrupt low while any unmasked status set and enabled
module hwm_alarm (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Host register access
  input wire hwm_pkg::hwm_bus_t bus,
  output logic [7:0] rdata,
  // Measurements and limits
  input wire hwm_pkg::hwm_meas_t meas,
  input wire hwm_pkg::hwm_limits_t lim,
  // Pins
  output logic system_mgmt_irq_n,
  output logic system_mgmt_irq_oe,
  output logic overheat_out_n,
  output logic buzzer_gp_out_n,
  output logic monitor_active
);
  import hwm_pkg::*;

  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] sts1;
    logic [7:0] sts2;
    logic [7:0] mask1;
    logic [7:0] mask2;
    logic [7:0] tcfg;
    logic [8:0] temp_a;
    logic [7:0] temp_b;
    logic a_armed;
    logic a_pend;
    logic b_over;
    logic b_pend;
    logic ovt_on;
    logic ovt_above;
    logic ovt_wait;
    logic [7:0] rdata;
  } hwm_state_t;
  hwm_state_t st_r, st_nxt;

  logic run;
  logic sample;
  logic rd_sts;
  logic [HWM_NVOLT-1:0] v_evt;
  logic [HWM_NFAN-1:0] f_evt;
  logic a_over, a_below, b_over, b_below;
  hwm_tmode_t a_mode, b_mode;

  // RULE16 RULE18 monitoring runs only when started and not halted
  assign run = st_r.cfg[HWM_CFG_START] && !st_r.cfg[HWM_CFG_HALT];
  assign sample = meas.done && run;
  assign rd_sts = bus.rd && (bus.addr == HWM_ADDR_STS1 || bus.addr == HWM_ADDR_STS2);

  // Signed compares, two's-complement temperatures
  assign a_over = $signed(meas.temp_a) > $signed(lim.temp_a_over);
  assign a_below = $signed(meas.temp_a) < $signed(lim.temp_a_hyst);
  assign b_over = $signed(meas.temp_b) > $signed(lim.temp_b_over);
  assign b_below = $signed(meas.temp_b) < $signed(lim.temp_b_hyst);

  // RULE23 sensor A mode from its config bits
  always_comb begin
    case (st_r.tcfg[HWM_TMODE_LSB +: 2])
      2'b01: a_mode = hwm_tm_two;
      2'b10: a_mode = hwm_tm_one;
      default: a_mode = hwm_tm_cmp;
    endcase
  end

  // RULE3 RULE6 sensor B mode set by hysteresis programming
  assign b_mode = (lim.temp_b_hyst == HWM_HYST_CMP) ? hwm_tm_cmp : hwm_tm_two;

  // Spare voltage channel is tracked like the rest but has no status bit
  genvar gi;
  generate
    for (gi = 0; gi < HWM_NVOLT; gi++) begin : g_volt
      hwm_edge_alarm u_volt ( // RULE11
        .clk(clk),
        .reset_n(reset_n),
        .sample(sample),
        .outside(meas.volt[gi*8 +: 8] > lim.volt_hi[gi*8 +: 8] ||
                 meas.volt[gi*8 +: 8] < lim.volt_lo[gi*8 +: 8]),
        .clear(st_r.cfg[HWM_CFG_INIT]),
        .event_p(v_evt[gi])
      );
    end
    for (gi = 0; gi < HWM_NFAN; gi++) begin : g_fan
      hwm_edge_alarm u_fan ( // RULE12
        .clk(clk),
        .reset_n(reset_n),
        .sample(sample),
        .outside(meas.fan[gi*8 +: 8] > lim.fan_lim[gi*8 +: 8]),
        .clear(st_r.cfg[HWM_CFG_INIT]),
        .event_p(f_evt[gi])
      );
    end
  endgenerate

  always_comb begin
    logic ev_a;
    logic ev_b;
    logic ovt_clr;
    logic ovt_set;
    logic [7:0] set1;
    logic [7:0] set2;
    ev_a = 1'b0;
    ev_b = 1'b0;
    ovt_clr = 1'b0;
    ovt_set = 1'b0;
    set1 = 8'h00;
    set2 = 8'h00;
    st_nxt = st_r;
    st_nxt.rdata = st_r.rdata;

    if (sample) begin
      st_nxt.temp_a = meas.temp_a; // RULE1
      st_nxt.temp_b = meas.temp_b; // RULE1
      // Sensor B interrupt
      case (b_mode)
        hwm_tm_cmp: begin
          // RULE4 fires on every conversion above limit once cleared
          ev_b = b_over && !st_r.b_pend;
        end
        default: begin
          // RULE7 over event, then below-hysteresis event
          if (!st_r.b_over && b_over) begin
            ev_b = 1'b1;
            st_nxt.b_over = 1'b1;
          end else if (st_r.b_over && b_below) begin
            ev_b = !st_r.b_pend;
            st_nxt.b_over = 1'b0;
          end
        end
      endcase
      // Sensor A interrupt
      case (a_mode)
        hwm_tm_cmp: begin
          // RULE5 armed from over-limit until below hysteresis
          if (a_over) begin
            st_nxt.a_armed = 1'b1;
          end else if (a_below) begin
            st_nxt.a_armed = 1'b0;
          end
          ev_a = (a_over || (st_r.a_armed && !a_below)) && !st_r.a_pend;
        end
        hwm_tm_two: begin
          // RULE7
          if (!st_r.a_armed && a_over) begin
            ev_a = 1'b1;
            st_nxt.a_armed = 1'b1;
          end else if (st_r.a_armed && a_below) begin
            ev_a = !st_r.a_pend;
            st_nxt.a_armed = 1'b0;
          end
        end
        default: begin
          // RULE8 rearm only after dropping below hysteresis
          if (!st_r.a_armed && a_over) begin
            ev_a = 1'b1;
            st_nxt.a_armed = 1'b1;
          end else if (st_r.a_armed && a_below) begin
            st_nxt.a_armed = 1'b0;
          end
        end
      endcase
      // Overheat output
      if (!st_r.tcfg[HWM_OVT_LATCH]) begin
        // RULE9
        if (a_over) begin
          st_nxt.ovt_on = 1'b1;
        end else if (a_below) begin
          st_nxt.ovt_on = 1'b0;
        end
      end else begin
        // RULE10 latch on crossing; a read waits for the drop
        if (!st_r.ovt_above && a_over) begin
          st_nxt.ovt_on = 1'b1;
          st_nxt.ovt_above = 1'b1;
          ovt_set = 1'b1;
        end else if (st_r.ovt_above && a_below) begin
          st_nxt.ovt_above = 1'b0;
          if (st_r.ovt_wait) begin
            st_nxt.ovt_on = 1'b1;
            ovt_set = 1'b1;
            st_nxt.ovt_wait = 1'b0;
          end
        end
      end
    end

    set1[HWM_S1_TEMPA] = ev_a;
    set1[HWM_S1_TEMPB] = ev_b;
    set1[HWM_S1_FANA] = f_evt[0];
    set1[HWM_S1_FANB] = f_evt[1];
    set1[0] = v_evt[0];
    set1[2] = v_evt[1];
    set1[3] = v_evt[2];
    set2[0] = v_evt[3];
    set2[1] = v_evt[4];
    set2[2] = v_evt[5];
    set2[HWM_S2_FANC] = f_evt[2];
    // v_evt[6] is the spare channel with no status bit
    if (ev_a) begin
      st_nxt.a_pend = 1'b1;
    end
    if (ev_b) begin
      st_nxt.b_pend = 1'b1;
    end

    // Register reads
    if (bus.rd) begin
      if (bus.addr == HWM_ADDR_CFG) begin
        st_nxt.rdata = st_r.cfg;
      end else if (bus.addr == HWM_ADDR_STS1) begin
        st_nxt.rdata = st_r.sts1 & HWM_S1_USED; // RULE20
      end else if (bus.addr == HWM_ADDR_STS2) begin
        st_nxt.rdata = st_r.sts2 & HWM_S2_USED; // RULE21
      end else if (bus.addr == HWM_ADDR_MASK1) begin
        st_nxt.rdata = st_r.mask1;
      end else if (bus.addr == HWM_ADDR_MASK2) begin
        st_nxt.rdata = st_r.mask2;
      end else if (bus.addr == HWM_ADDR_TEMPB) begin
        st_nxt.rdata = st_r.temp_b;
        ovt_clr = 1'b1;
      end else if (bus.addr == HWM_ADDR_TEMPA_HI) begin
        st_nxt.rdata = st_r.temp_a[8:1]; // RULE2
        ovt_clr = 1'b1;
      end else if (bus.addr == HWM_ADDR_TEMPA_LO) begin
        st_nxt.rdata = {st_r.temp_a[0], 7'h00}; // RULE2
        ovt_clr = 1'b1;
      end else if (bus.addr == HWM_ADDR_TEMPA_CFG) begin
        st_nxt.rdata = st_r.tcfg;
      end else begin
        st_nxt.rdata = HWM_RST_ZERO;
      end
    end

    // RULE10 temperature read releases a latched output
    // A fresh latch in the read cycle wins, or the host would miss it
    if (ovt_clr && st_r.tcfg[HWM_OVT_LATCH] && st_r.ovt_on && !ovt_set) begin
      st_nxt.ovt_on = 1'b0;
      st_nxt.ovt_wait = st_r.ovt_above;
    end

    // RULE13 read clears; a same-cycle event still sets
    if (rd_sts) begin
      st_nxt.sts1 = set1;
      st_nxt.sts2 = set2;
      st_nxt.a_pend = ev_a;
      st_nxt.b_pend = ev_b;
    end else begin
      st_nxt.sts1 = st_r.sts1 | set1;
      st_nxt.sts2 = st_r.sts2 | set2;
    end

    // Register writes; RULE19 config write leaves status alone unless bit 7 restores defaults
    if (bus.wr) begin
      if (bus.addr == HWM_ADDR_CFG) begin
        st_nxt.cfg = bus.wdata;
      end else if (bus.addr == HWM_ADDR_MASK1) begin
        st_nxt.mask1 = bus.wdata;
      end else if (bus.addr == HWM_ADDR_MASK2) begin
        st_nxt.mask2 = bus.wdata & HWM_S2_USED;
      end else if (bus.addr == HWM_ADDR_TEMPA_CFG) begin
        st_nxt.tcfg = bus.wdata;
      end
    end

    // RULE14 restore defaults one cycle after the write, bit self-clears
    if (st_r.cfg[HWM_CFG_INIT]) begin
      st_nxt = '0;
      st_nxt.cfg = HWM_RST_CFG;
      st_nxt.tcfg = HWM_RST_MODE;
      st_nxt.rdata = st_r.rdata;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '0;
      st_r.cfg <= HWM_RST_CFG;
      st_r.tcfg <= HWM_RST_MODE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata = st_r.rdata;
  assign monitor_active = run;
  // RULE22 RULE24 any unmasked status pulls the line low
  assign system_mgmt_irq_n = !(|(st_r.sts1 & ~st_r.mask1) || |(st_r.sts2 & ~st_r.mask2));
  // RULE16 RULE17 output enabled only with bit 1 set and bit 3 clear
  assign system_mgmt_irq_oe = st_r.cfg[HWM_CFG_IRQ_EN] && !st_r.cfg[HWM_CFG_HALT];
  assign overheat_out_n = !st_r.ovt_on;
  assign buzzer_gp_out_n = !st_r.cfg[HWM_CFG_BUZZ]; // RULE15
endmodule
`default_nettype wire

/* File: hwm_alarm_checker.sv */
// Purpose: port assertions for the alarm block
// Assumes: one clock, async low reset
// Notes: tracks overheat mode bit and last sensor A sample
`timescale 1ns/10ps
`default_nettype none
module hwm_alarm_checker import hwm_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Host side
  input wire hwm_pkg::hwm_bus_t bus,
  input wire logic [7:0] rdata,
  // Measurements
  input wire hwm_pkg::hwm_meas_t meas,
  input wire hwm_pkg::hwm_limits_t lim,
  // Pins
  input wire logic system_mgmt_irq_n,
  input wire logic system_mgmt_irq_oe,
  input wire logic overheat_out_n,
  input wire logic buzzer_gp_out_n,
  input wire logic monitor_active
);
  logic lat_r;
  logic [8:0] ta_r;
  wire logic cfg_wr = bus.wr && bus.addr == HWM_ADDR_CFG;
  wire logic take = meas.done && monitor_active;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lat_r <= 1'b0;
      ta_r <= '0;
    end else if (cfg_wr && bus.wdata[7]) begin
      lat_r <= 1'b0;
      ta_r <= '0;
    end else begin
      if (bus.wr && bus.addr == HWM_ADDR_TEMPA_CFG) begin
        lat_r <= bus.wdata[HWM_OVT_LATCH];
      end
      if (take) begin
        ta_r <= meas.temp_a;
      end
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence cfg_plain;
    cfg_wr && !bus.wdata[7];
  endsequence
  // Clear read with no conversion landing around it
  sequence quiet_read;
    !meas.done ##1 (bus.rd && bus.addr == HWM_ADDR_STS1 && !meas.done);
  endsequence
  buzz_follow_a: assert property (
    cfg_plain |=> buzzer_gp_out_n == !$past(bus.wdata[6])) else $error("buzzer pin wrong");
  irq_enable_a: assert property (
    cfg_plain |=> system_mgmt_irq_oe == ($past(bus.wdata[1]) && !$past(bus.wdata[3]))) else $error("irq enable wrong");
  monitor_run_a: assert property (
    cfg_plain |=> monitor_active == ($past(bus.wdata[0]) && !$past(bus.wdata[3]))) else $error("monitor state wrong");
  init_restore_a: assert property (
    cfg_wr && bus.wdata[7] |-> ##[1:2] (monitor_active && !system_mgmt_irq_oe && buzzer_gp_out_n))
    else $error("init write failed");
  sts2_zero_a: assert property (
    bus.rd && bus.addr == HWM_ADDR_STS2 |=> rdata[7:4] == 4'h0) else $error("status two upper bits set");
  read_clear_a: assert property (
    quiet_read |=> system_mgmt_irq_n || !system_mgmt_irq_oe) else $error("irq not cleared by read");
  ovt_on_a: assert property (
    !lat_r && take && $signed(meas.temp_a) > $signed(lim.temp_a_over) |=> !overheat_out_n)
    else $error("overheat not active");
  ovt_off_a: assert property (
    !lat_r && take && $signed(meas.temp_a) < $signed(lim.temp_a_hyst) |=> overheat_out_n)
    else $error("overheat not released");
  temp_hi_a: assert property (
    bus.rd && bus.addr == HWM_ADDR_TEMPA_HI |=> rdata == $past(ta_r[8:1])) else $error("sensor A read wrong");
endmodule
bind hwm_alarm hwm_alarm_checker chk (.clk(clk), .reset_n(reset_n), .bus(bus), .rdata(rdata), .meas(meas),
  .lim(lim), .system_mgmt_irq_n(system_mgmt_irq_n), .system_mgmt_irq_oe(system_mgmt_irq_oe),
  .overheat_out_n(overheat_out_n), .buzzer_gp_out_n(buzzer_gp_out_n), .monitor_active(monitor_active));
`default_nettype wire

/* File: hwm_edge_alarm.sv */
// Purpose: two-times alarm event for one voltage or fan channel
// Assumes: one comparison result per completed conversion
// Notes: event on every change of the out-of-limit state
`timescale 1ns/10ps
`default_nettype none
module hwm_edge_alarm (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Comparison
  input wire logic sample,
  input wire logic outside,
  input wire logic clear,
  // Result
  output logic event_p
);
  typedef struct packed {
    logic outside;
  } hwm_ea_state_t;
  hwm_ea_state_t st_r, st_nxt;

  always_comb begin
    st_nxt = st_r;
    event_p = 1'b0;
    if (clear) begin
      st_nxt.outside = 1'b0;
    end else if (sample) begin
      st_nxt.outside = outside;
      // Both entering and leaving the limit window report
      event_p = outside != st_r.outside;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule
`default_nettype wire

/* File: hwm_host.sv */
// Purpose: host model driving the register index bus
// Assumes: one-cycle strobes, read data one cycle after
// Notes: data lines flipped after each write
`timescale 1ns/10ps
`default_nettype none
module hwm_host import hwm_pkg::*; (
  // Clock
  input wire logic clk,
  // Register bus
  output var hwm_pkg::hwm_bus_t bus,
  input wire logic [7:0] rdata
);
  initial bus = '0;
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge clk);
    bus.wr <= 1'b0;
    bus.wdata <= ~d;
    #1;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clk);
    bus.rd <= 1'b0;
    #1;
    d = rdata;
  endtask
endmodule
`default_nettype wire

/* File: hwm_pkg.sv */
// Purpose: shared constants and carriers for the limit and alarm block
// Assumes: registers reached by an 8-bit index with read and write strobes
// Notes: limit values arrive as ports, not as RAM held here
package hwm_pkg;
  localparam logic [7:0] HWM_ADDR_CFG = 8'h40;
  localparam logic [7:0] HWM_ADDR_STS1 = 8'h41;
  localparam logic [7:0] HWM_ADDR_STS2 = 8'h42;
  localparam logic [7:0] HWM_ADDR_MASK1 = 8'h43;
  localparam logic [7:0] HWM_ADDR_MASK2 = 8'h44;
  localparam logic [7:0] HWM_ADDR_TEMPB = 8'h27;
  localparam logic [7:0] HWM_ADDR_TEMPA_HI = 8'h50;
  localparam logic [7:0] HWM_ADDR_TEMPA_LO = 8'h51;
  localparam logic [7:0] HWM_ADDR_TEMPA_CFG = 8'h52;
  localparam logic [7:0] HWM_RST_CFG = 8'h01;
  localparam logic [7:0] HWM_RST_ZERO = 8'h00;
  localparam logic [7:0] HWM_RST_MODE = 8'h00;
  localparam logic [7:0] HWM_HYST_CMP = 8'h7F;
  localparam int HWM_CFG_INIT = 7;
  localparam int HWM_CFG_BUZZ = 6;
  localparam int HWM_CFG_HALT = 3;
  localparam int HWM_CFG_IRQ_EN = 1;
  localparam int HWM_CFG_START = 0;
  localparam int HWM_OVT_LATCH = 2;
  localparam int HWM_TMODE_LSB = 0;
  localparam int HWM_LO_LSB = 7;
  localparam int HWM_NVOLT = 7;
  localparam int HWM_NFAN = 3;
  // Status bit positions
  localparam int HWM_S1_FANB = 7;
  localparam int HWM_S1_FANA = 6;
  localparam int HWM_S1_TEMPA = 5;
  localparam int HWM_S1_TEMPB = 4;
  localparam int HWM_S2_FANC = 3;
  localparam logic [7:0] HWM_S2_USED = 8'h0F;
  localparam logic [7:0] HWM_S1_USED = 8'hFD;

  typedef enum logic [1:0] {hwm_tm_cmp, hwm_tm_two, hwm_tm_one} hwm_tmode_t;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } hwm_bus_t;

  // One completed conversion round, all channels
  typedef struct packed {
    logic done;
    logic [8:0] temp_a;
    logic [7:0] temp_b;
    logic [HWM_NVOLT*8-1:0] volt;
    logic [HWM_NFAN*8-1:0] fan;
  } hwm_meas_t;

  typedef struct packed {
    logic [8:0] temp_a_over;
    logic [8:0] temp_a_hyst;
    logic [7:0] temp_b_over;
    logic [7:0] temp_b_hyst;
    logic [HWM_NVOLT*8-1:0] volt_hi;
    logic [HWM_NVOLT*8-1:0] volt_lo;
    logic [HWM_NFAN*8-1:0] fan_lim;
  } hwm_limits_t;
endpackage

/* File: tb.sv */
// Purpose: self-checking bench for the alarm block
// Assumes: host model on the bus, bench drives conversions
// Notes: expectations worked out from limits set here
`timescale 1ns/10ps
`default_nettype none
module tb;
  import hwm_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  hwm_bus_t bus;
  hwm_meas_t meas;
  hwm_limits_t lim;
  logic [7:0] rdata, d, v;
  logic irq_n, irq_oe, ovt_n, buzz_n, mon;
  logic [8:0] ta;
  int fail_count, num_checks, cycles;
  int seed = 47021;
  logic [7:0] vaddr [6] = '{8'h41, 8'h41, 8'h41, 8'h42, 8'h42, 8'h42};
  logic [7:0] vbit [6] = '{8'h01, 8'h04, 8'h08, 8'h01, 8'h02, 8'h04};
  logic [7:0] fbit [3] = '{8'h40, 8'h80, 8'h08};
  // Pulled-up pin seen by the host
  wire logic irq_pin = irq_oe ? irq_n : 1'b1;
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      fail_count++;
      give_verdict();
    end
  end
  hwm_alarm uut (.clk(clk), .reset_n(reset_n), .bus(bus), .rdata(rdata), .meas(meas), .lim(lim),
    .system_mgmt_irq_n(irq_n), .system_mgmt_irq_oe(irq_oe), .overheat_out_n(ovt_n),
    .buzzer_gp_out_n(buzz_n), .monitor_active(mon));
  hwm_host host (.clk(clk), .bus(bus), .rdata(rdata));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  function automatic logic [7:0] pins(input logic [7:0] c);
    return {5'h00, !c[6], c[1] && !c[3], c[0] && !c[3]};
  endfunction
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    host.rd_reg(a, d);
    check(d, e);
  endtask
  task automatic conv;
    @(posedge clk);
    meas.done <= 1'b1;
    @(posedge clk);
    meas.done <= 1'b0;
    @(posedge clk);
    #1;
  endtask
  task automatic tstep(input logic [8:0] a, input logic [7:0] b, input logic [7:0] e);
    @(posedge clk);
    meas.temp_a <= a;
    meas.temp_b <= b;
    conv;
    rchk(HWM_ADDR_STS1, e);
  endtask
  initial begin
    meas = '0;
    meas.volt = {7{8'h50}};
    meas.fan = {3{8'h40}};
    lim = '0;
    lim.temp_a_over = 9'h0A0;
    lim.temp_a_hyst = 9'h090;
    lim.temp_b_over = 8'h50;
    lim.temp_b_hyst = HWM_HYST_CMP;
    lim.volt_hi = {7{8'h80}};
    lim.volt_lo = {7{8'h20}};
    lim.fan_lim = {3{8'h80}};
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    rchk(HWM_ADDR_CFG, HWM_RST_CFG);
    rchk(HWM_ADDR_STS1, 8'h00);
    rchk(HWM_ADDR_STS2, 8'h00);
    rchk(HWM_ADDR_MASK1, 8'h00);
    rchk(8'h4F, 8'h00);
    for (int i = 0; i < 4; i++) begin
      v = $random(seed) & 8'h4B;
      host.wr_reg(HWM_ADDR_CFG, v);
      check({5'h00, buzz_n, irq_oe, mon}, pins(v));
      rchk(HWM_ADDR_CFG, v);
    end
    host.wr_reg(HWM_ADDR_MASK1, 8'hA5);
    host.wr_reg(HWM_ADDR_CFG, 8'hC2);
    rchk(HWM_ADDR_CFG, HWM_RST_CFG);
    rchk(HWM_ADDR_MASK1, 8'h00);
    $display("config test done");
    host.wr_reg(HWM_ADDR_CFG, 8'h03);
    for (int ch = 0; ch < 6; ch++) begin
      v = $random(seed);
      @(posedge clk);
      meas.volt[ch*8 +: 8] <= v[7] ? (8'h90 | (v & 8'h3F)) : (v & 8'h1F);
      conv;
      check({7'h00, irq_pin}, 8'h00);
      rchk(vaddr[ch], vbit[ch]);
      check({7'h00, irq_pin}, 8'h01);
      conv;
      rchk(vaddr[ch], 8'h00);
      @(posedge clk);
      meas.volt[ch*8 +: 8] <= 8'h50;
      conv;
      rchk(vaddr[ch], vbit[ch]);
    end
    for (int f = 0; f < 3; f++) begin
      @(posedge clk);
      meas.fan[f*8 +: 8] <= 8'hC0;
      conv;
      rchk(f == 2 ? HWM_ADDR_STS2 : HWM_ADDR_STS1, fbit[f]);
      @(posedge clk);
      meas.fan[f*8 +: 8] <= 8'h40;
      conv;
      rchk(f == 2 ? HWM_ADDR_STS2 : HWM_ADDR_STS1, fbit[f]);
    end
    $display("limit test done");
    host.wr_reg(HWM_ADDR_MASK1, 8'h08);
    @(posedge clk);
    meas.volt[23:16] <= 8'hA0;
    conv;
    check({7'h00, irq_pin}, 8'h01);
    host.wr_reg(HWM_ADDR_MASK1, 8'h00);
    check({7'h00, irq_pin}, 8'h00);
    host.wr_reg(HWM_ADDR_CFG, 8'h00);
    check({7'h00, irq_n}, 8'h00);
    host.wr_reg(HWM_ADDR_CFG, 8'h0B);
    check({7'h00, irq_oe}, 8'h00);
    rchk(HWM_ADDR_STS1, 8'h08);
    @(posedge clk);
    meas.volt[23:0] <= 24'h50_50_10;
    conv;
    rchk(HWM_ADDR_STS1, 8'h00);
    host.wr_reg(HWM_ADDR_CFG, 8'h03);
    conv;
    rchk(HWM_ADDR_STS1, 8'h09);
    @(posedge clk);
    meas.volt[7:0] <= 8'h50;
    conv;
    rchk(HWM_ADDR_STS1, 8'h01);
    host.wr_reg(HWM_ADDR_MASK2, 8'hFF);
    rchk(HWM_ADDR_MASK2, 8'h0F);
    @(posedge clk);
    meas.volt[31:24] <= 8'hA0;
    conv;
    check({7'h00, irq_pin}, 8'h01);
    host.wr_reg(HWM_ADDR_MASK2, 8'h00);
    check({7'h00, irq_pin}, 8'h00);
    rchk(HWM_ADDR_STS2, 8'h01);
    $display("mask test done");
    tstep(9'h000, 8'h60, 8'h10);
    tstep(9'h000, 8'h60, 8'h10);
    tstep(9'h000, 8'h00, 8'h00);
    @(posedge clk);
    lim.temp_b_hyst <= 8'h40;
    tstep(9'h000, 8'h60, 8'h10);
    tstep(9'h000, 8'h60, 8'h00);
    tstep(9'h000, 8'h00, 8'h10);
    ta = 9'h0A1 + 9'($random(seed) & 8'h3F);
    tstep(ta, 8'h00, 8'h20);
    check({7'h00, ovt_n}, 8'h00);
    rchk(HWM_ADDR_TEMPA_HI, ta[8:1]);
    tstep(9'h095, 8'h00, 8'h20);
    check({7'h00, ovt_n}, 8'h00);
    host.rd_reg(HWM_ADDR_TEMPA_LO, d);
    check(d & 8'h80, 8'h80);
    tstep(9'h080, 8'h00, 8'h00);
    check({7'h00, ovt_n}, 8'h01);
    for (int m = 1; m < 3; m++) begin
      host.wr_reg(HWM_ADDR_TEMPA_CFG, 8'(m));
      tstep(9'h0A8, 8'h00, 8'h20);
      tstep(9'h0A8, 8'h00, 8'h00);
      tstep(9'h000, 8'h00, m == 1 ? 8'h20 : 8'h00);
    end
    $display("temperature test done");
    host.wr_reg(HWM_ADDR_TEMPA_CFG, 8'h04);
    tstep(9'h0A8, 8'h00, 8'h20);
    check({7'h00, ovt_n}, 8'h00);
    rchk(HWM_ADDR_TEMPA_CFG, 8'h04);
    rchk(HWM_ADDR_TEMPA_HI, 8'h54);
    check({7'h00, ovt_n}, 8'h01);
    tstep(9'h0A8, 8'h00, 8'h20);
    check({7'h00, ovt_n}, 8'h01);
    tstep(9'h080, 8'h00, 8'h00);
    check({7'h00, ovt_n}, 8'h00);
    rchk(HWM_ADDR_TEMPB, 8'h00);
    check({7'h00, ovt_n}, 8'h01);
    $display("overheat latch test done");
    give_verdict();
  end
endmodule
`default_nettype wire
